// File: design/drps_sequencer.v
// Dual rail power sequencer with reset supervisor and APB registers
// Functional notes
// - Order low: rail A first, B at 83%
// - Output good released at rail A 95%
// - System reset released after 120ms delay
// - Order high: rail B first, A at 83%
// - Manual reset A forces reset, rails stay
// - Order high: rail A fault keeps B on
// - Order high: rail B fault drops A
// - Rail A fault drops output good
// - Enable high means shutdown, both rails off
// - Rail B below 95% resets at once
// - Release needs both manual resets inactive
// - Open order input reads as high
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "drps_consts.vh"
module drps_sequencer #(
    parameter RELEASE_CYCLES = (`DRPS_RELEASE_MS * `DRPS_CLOCK_KHZ),
    parameter CNT_W = 24
) (
    input wire clock,
    input wire rst_b,
    input wire clock_en,
    input wire enable_b,
    input wire order_select,
    input wire manual_reset_a_b,
    input wire manual_reset_b_b,
    input wire rail_a_83,
    input wire rail_a_95,
    input wire rail_b_83,
    input wire rail_b_95,
    output wire rail_a_enable,
    output wire rail_b_enable,
    output wire output1_good_in,
    output wire output1_good_out,
    output wire output1_good_oe,
    output wire sys_reset_b_in,
    output wire sys_reset_b_out,
    output wire sys_reset_b_oe,
    output wire irq,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    // =====================================================
    // Pin synchronisers
    // =====================================================
    wire [8:0] pins_sync;
    wire en_b_s;
    wire order_s;
    wire mra_s;
    wire mrb_s;
    wire a83_s;
    wire a95_s;
    wire b83_s;
    wire b95_s;
    wire unused_s;

    drps_sync2 #(.WIDTH(9), .INIT(9'h00f)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .clock_en(clock_en),
        .async_in({1'b0, rail_b_95, rail_b_83, rail_a_95, rail_a_83,
            manual_reset_b_b, manual_reset_a_b, order_select, enable_b}),
        .sync_out(pins_sync)
    );
    assign en_b_s = pins_sync[0];
    assign order_s = pins_sync[1];
    assign mra_s = pins_sync[2];
    assign mrb_s = pins_sync[3];
    assign a83_s = pins_sync[4];
    assign a95_s = pins_sync[5];
    assign b83_s = pins_sync[6];
    assign b95_s = pins_sync[7];
    assign unused_s = pins_sync[8];

    // =====================================================
    // Registers
    // =====================================================
    reg sw_reset;
    reg [`DRPS_EV_W-1:0] irq_stat;
    reg [`DRPS_EV_W-1:0] irq_mask;
    reg en_a_q;
    reg en_b_q;
    reg good_q;
    reg sysrst_q;
    reg active_q;
    reg [CNT_W-1:0] delay_cnt;

    // =====================================================
    // Rail sequencing
    // =====================================================
    wire active;
    wire next_en_a;
    wire next_en_b;
    assign active = ~en_b_s;
    // Order low: A leads, B follows A at 83%; order high: B leads, A follows B
    assign next_en_a = active & (order_s ? b83_s : 1'b1);
    assign next_en_b = active & (order_s ? 1'b1 : a83_s);

    // =====================================================
    // Reset release supervisor
    // =====================================================
    wire release_ok;
    wire count_done;
    assign release_ok = active & b95_s & mra_s & mrb_s & ~sw_reset;
    assign count_done = (delay_cnt >= RELEASE_CYCLES[CNT_W-1:0] - 1'b1);

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            en_a_q <= 1'b0;
            en_b_q <= 1'b0;
            good_q <= 1'b0;
            sysrst_q <= 1'b0;
            active_q <= 1'b0;
            delay_cnt <= {CNT_W{1'b0}};
        end else if (clock_en) begin
            en_a_q <= next_en_a;
            en_b_q <= next_en_b;
            active_q <= active;
            good_q <= a95_s;
            if (!release_ok) begin
                delay_cnt <= {CNT_W{1'b0}};
                sysrst_q <= 1'b0;
            end else if (count_done) begin
                sysrst_q <= 1'b1;
            end else begin
                delay_cnt <= delay_cnt + 1'b1;
            end
        end
    end

    assign rail_a_enable = en_a_q;
    assign rail_b_enable = en_b_q;
    // Open drain: drive low when not good
    assign output1_good_out = 1'b0;
    assign output1_good_oe = ~good_q;
    assign output1_good_in = good_q;
    assign sys_reset_b_out = 1'b0;
    assign sys_reset_b_oe = ~sysrst_q;
    assign sys_reset_b_in = sysrst_q;

    // =====================================================
    // Interrupt events
    // =====================================================
    reg good_d;
    reg sysrst_d;
    reg en_a_d;
    wire [`DRPS_EV_W-1:0] events;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            good_d <= 1'b0;
            sysrst_d <= 1'b0;
            en_a_d <= 1'b0;
        end else if (clock_en) begin
            good_d <= good_q;
            sysrst_d <= sysrst_q;
            en_a_d <= en_a_q;
        end
    end
    assign events[`DRPS_EV_GOOD_RISE] = good_q & ~good_d;
    assign events[`DRPS_EV_GOOD_FALL] = ~good_q & good_d;
    assign events[`DRPS_EV_RST_REL] = sysrst_q & ~sysrst_d;
    assign events[`DRPS_EV_RST_ASSERT] = ~sysrst_q & sysrst_d;
    assign events[`DRPS_EV_FAULT_B] = ~en_a_q & en_a_d & order_s & active;
    assign irq = |(irq_stat & irq_mask);

    // =====================================================
    // APB slave
    // =====================================================
    wire wr_acc;
    wire rd_acc;
    wire mapped;
    assign wr_acc = psel & penable & pwrite;
    // Read data loads in the setup phase so it stands through the access phase
    assign rd_acc = psel & ~penable & ~pwrite;
    assign mapped = (paddr == `DRPS_OFF_CTRL) | (paddr == `DRPS_OFF_STATUS) |
        (paddr == `DRPS_OFF_IRQ_STAT) | (paddr == `DRPS_OFF_IRQ_MASK);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sw_reset <= 1'b0;
            irq_mask <= `DRPS_IRQ_MASK_RST;
            irq_stat <= {`DRPS_EV_W{1'b0}};
            prdata <= 32'h0000_0000;
        end else if (clock_en) begin
            if (wr_acc && paddr == `DRPS_OFF_CTRL) begin
                sw_reset <= pwdata[`DRPS_CTRL_SW_RESET];
            end
            if (wr_acc && paddr == `DRPS_OFF_IRQ_MASK) begin
                irq_mask <= pwdata[`DRPS_EV_W-1:0];
            end
            // Set wins over write-one-to-clear
            if (wr_acc && paddr == `DRPS_OFF_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[`DRPS_EV_W-1:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
            if (rd_acc) begin
                case (paddr)
                    `DRPS_OFF_CTRL: prdata <= {31'h0, sw_reset};
                    `DRPS_OFF_STATUS: prdata <= {26'h0, active_q, order_s, sysrst_q,
                        good_q, en_b_q, en_a_q};
                    `DRPS_OFF_IRQ_STAT: prdata <= {27'h0, irq_stat};
                    `DRPS_OFF_IRQ_MASK: prdata <= {27'h0, irq_mask};
                    default: prdata <= {31'h0, unused_s};
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: pkg/drps_consts.vh
// Constants of the dual rail power sequencer
`ifndef DRPS_CONSTS_VH
`define DRPS_CONSTS_VH

// Register byte offsets
`define DRPS_OFF_CTRL 12'h000
`define DRPS_OFF_STATUS 12'h004
`define DRPS_OFF_IRQ_STAT 12'h008
`define DRPS_OFF_IRQ_MASK 12'h00c

// Control register fields
`define DRPS_CTRL_SW_RESET 0
`define DRPS_CTRL_RST 32'h0000_0000

// Status register fields
`define DRPS_ST_EN_A 0
`define DRPS_ST_EN_B 1
`define DRPS_ST_GOOD 2
`define DRPS_ST_SYSRST 3
`define DRPS_ST_ORDER 4
`define DRPS_ST_ACTIVE 5

// Interrupt event bits
`define DRPS_EV_GOOD_RISE 0
`define DRPS_EV_GOOD_FALL 1
`define DRPS_EV_RST_REL 2
`define DRPS_EV_RST_ASSERT 3
`define DRPS_EV_FAULT_B 4
`define DRPS_EV_W 5
`define DRPS_IRQ_MASK_RST 5'h00

// Reset release delay
`define DRPS_RELEASE_MS 120
`define DRPS_CLOCK_KHZ 100000

`endif

// File: design/drps_sync2.v
// Two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/100ps
`default_nettype none
module drps_sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clock,
    input wire rst_b,
    input wire clock_en,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= INIT;
            stage2 <= INIT;
        end else if (clock_en) begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end
    assign sync_out = stage2;
endmodule
`default_nettype wire

// File: verif/drps_sequencer_sva.sv
// Assertion checker for the dual rail power sequencer
`timescale 1ns/100ps
`default_nettype none
module drps_sequencer_sva #(
    parameter RELEASE_CYCLES = 20
) (
    input wire clock,
    input wire rst_b,
    input wire enable_b,
    input wire order_select,
    input wire manual_reset_a_b,
    input wire manual_reset_b_b,
    input wire rail_a_83,
    input wire rail_a_95,
    input wire rail_b_83,
    input wire rail_b_95,
    input wire rail_a_enable,
    input wire rail_b_enable,
    input wire output1_good_in,
    input wire output1_good_oe,
    input wire sys_reset_b_oe
);
    int ok_cnt;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ok_cnt <= 0;
        end else begin
            ok_cnt <= (rail_b_95 && manual_reset_a_b && manual_reset_b_b) ? ok_cnt + 1 : 0;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    AST_OFF: assert property (enable_b [*4] |-> !rail_a_enable && !rail_b_enable)
        else $error("rail on in shutdown");
    AST_A_FIRST: assert property ((!order_select && !rail_a_83) [*4] |-> !rail_b_enable)
        else $error("rail b on early");
    AST_B_ON: assert property ((!order_select && !enable_b && rail_a_83) [*4] |-> rail_b_enable)
        else $error("rail b not on");
    AST_B_FIRST: assert property ((order_select && !rail_b_83) [*4] |-> !rail_a_enable)
        else $error("rail a on without b");
    AST_A_ON: assert property ((order_select && !enable_b && rail_b_83) [*4] |-> rail_a_enable)
        else $error("rail a not on");
    AST_B_KEPT: assert property ((order_select && !enable_b) [*4] |-> rail_b_enable)
        else $error("rail b dropped");
    AST_GOOD: assert property (rail_a_95 [*4] |-> output1_good_in && !output1_good_oe)
        else $error("good not set");
    AST_GOOD_LOW: assert property (!rail_a_95 [*4] |-> output1_good_oe)
        else $error("good not low");
    AST_B_LOW: assert property (!rail_b_95 [*4] |-> sys_reset_b_oe)
        else $error("reset not held for rail b");
    AST_MR_A: assert property (!manual_reset_a_b [*4] |-> sys_reset_b_oe)
        else $error("reset not held for manual a");
    AST_MR_B: assert property (!manual_reset_b_b [*4] |-> sys_reset_b_oe)
        else $error("reset not held for manual b");
    AST_DELAY: assert property ($fell(sys_reset_b_oe) |-> $past(ok_cnt) >= RELEASE_CYCLES)
        else $error("reset released early");
    cover property ($fell(sys_reset_b_oe));
    cover property ($rose(rail_a_enable) && order_select);
    cover property ($rose(output1_good_oe));
endmodule
bind drps_sequencer drps_sequencer_sva #(.RELEASE_CYCLES(RELEASE_CYCLES)) drps_sequencer_sva_i (
    .clock(clock), .rst_b(rst_b), .enable_b(enable_b), .order_select(order_select),
    .manual_reset_a_b(manual_reset_a_b), .manual_reset_b_b(manual_reset_b_b),
    .rail_a_83(rail_a_83), .rail_a_95(rail_a_95), .rail_b_83(rail_b_83),
    .rail_b_95(rail_b_95), .rail_a_enable(rail_a_enable), .rail_b_enable(rail_b_enable),
    .output1_good_in(output1_good_in), .output1_good_oe(output1_good_oe),
    .sys_reset_b_oe(sys_reset_b_oe));
`default_nettype wire

// File: verif/drps_rail_model.sv
// Behavioural regulator rail with its two threshold comparators
`timescale 1ns/100ps
`default_nettype none
module drps_rail_model (
    input wire logic clock,
    input wire logic enable,
    input wire logic fault,
    output logic at_83,
    output logic at_95
);
    logic [2:0] level = 3'h0;
    // Ramps while enabled, collapses at once when off or overloaded
    always @(posedge clock) begin
        level <= (enable && !fault) ? level + {2'h0, level != 3'h7} : 3'h0;
    end
    assign at_83 = level >= 3'h3;
    assign at_95 = level >= 3'h6;
endmodule
`default_nettype wire

// File: verif/dual_rail_power_sequencer_tb.sv
// Self-checking testbench for the dual rail power sequencer
`timescale 1ns/100ps
`default_nettype none
`include "drps_consts.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module dual_rail_power_sequencer_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] pins = 6'h3c;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic serr;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    wire [31:0] prdata;
    wire pready, pslverr, ena, enb, a83, a95, b83, b95, good, good_oe, rst_oe, irq;
    wire good_out, rst_in, rst_out;
    // Pins: enable_b, order, manual reset a, manual reset b, fault a, fault b
    drps_sequencer #(.RELEASE_CYCLES(20)) drps_sequencer_i (.clock(clock), .rst_b(rst_b),
        .clock_en(1'b1), .enable_b(pins[5]), .order_select(pins[4]),
        .manual_reset_a_b(pins[3]), .manual_reset_b_b(pins[2] & !good_oe),
        .rail_a_83(a83), .rail_a_95(a95), .rail_b_83(b83), .rail_b_95(b95),
        .rail_a_enable(ena), .rail_b_enable(enb), .output1_good_in(good),
        .output1_good_out(good_out), .output1_good_oe(good_oe), .sys_reset_b_in(rst_in),
        .sys_reset_b_out(rst_out), .sys_reset_b_oe(rst_oe), .irq(irq), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    drps_rail_model drps_rail_model_i (.clock(clock), .enable(ena), .fault(pins[1]),
        .at_83(a83), .at_95(a95));
    drps_rail_model drps_rail_model_b_i (.clock(clock), .enable(enb), .fault(pins[0]),
        .at_83(b83), .at_95(b95));
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            stop_test;
        end
    end
    task stop_test;
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task setp(input logic [5:0] v);
        @(posedge clock);
        pins <= v;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        wt(1);
        `CHK("rails", 2'b00, {ena, enb})
        apb(1'b0, `DRPS_OFF_IRQ_MASK, 32'h0000_0000);
        `CHK("mask", 32'h0000_0000, rd)
        apb(1'b1, `DRPS_OFF_IRQ_MASK, 32'h0000_001f);
        apb(1'b0, 12'h010, 32'h0000_0000);
        `CHK("slverr", 1'b1, serr)
        setp(6'h1c);
        wt(8);
        `CHK("b first", 2'b01, {ena, enb})
        wt(25);
        `CHK("delay", 1'b1, rst_oe)
        wt(35);
        `CHK("up", 5'h1c, {ena, enb, good, good_oe, rst_oe})
        `CHK("pins", 3'b001, {good_out, rst_out, rst_in})
        apb(1'b0, `DRPS_OFF_STATUS, 32'h0000_0000);
        `CHK("status", 5'h1f, rd[4:0])
        `CHK("irq", 1'b1, irq)
        apb(1'b1, `DRPS_OFF_IRQ_STAT, 32'h0000_001f);
        `CHK("irq clr", 1'b0, irq)
        setp(6'h14);
        wt(6);
        `CHK("mr a", 3'b111, {ena, enb, rst_oe})
        `CHK("irq", 1'b1, irq)
        setp(6'h1c);
        apb(1'b1, `DRPS_OFF_IRQ_MASK, 32'h0000_0000);
        apb(1'b1, `DRPS_OFF_IRQ_STAT, 32'h0000_001f);
        `CHK("restart", 1'b1, rst_oe)
        setp(6'h14);
        setp(6'h1c);
        wt(18);
        `CHK("count restarted", 1'b1, rst_oe)
        wt(5);
        `CHK("late release", 1'b0, rst_oe)
        wt(30);
        `CHK("masked", 2'b00, {rst_oe, irq})
        setp(6'h1e);
        wt(8);
        `CHK("a fault", 3'b111, {enb, good_oe, rst_oe})
        setp(6'h1c);
        wt(60);
        setp(6'h1d);
        wt(8);
        `CHK("b fault", 2'b01, {ena, rst_oe})
        setp(6'h3c);
        wt(6);
        `CHK("off", 2'b00, {ena, enb})
        apb(1'b0, `DRPS_OFF_IRQ_STAT, 32'h0000_0000);
        `CHK("events", 32'h0000_001f, rd)
        setp(6'h0c);
        wt(6);
        `CHK("a first", 2'b10, {ena, enb})
        wt(60);
        `CHK("up low", 5'h1c, {ena, enb, good, good_oe, rst_oe})
        apb(1'b1, `DRPS_OFF_CTRL, 32'h0000_0001);
        wt(2);
        `CHK("sw reset", 1'b1, rst_oe)
        apb(1'b0, `DRPS_OFF_CTRL, 32'h0000_0000);
        `CHK("ctrl", 32'h0000_0001, rd)
        stop_test;
    end
endmodule
`default_nettype wire
